// ---- src/ddc_bind_consts.svh ----
// Named offsets, field positions and reset values of the preset and
// channel binding registers. Definitions only.
`ifndef DDC_BIND_CONSTS_SVH
`define DDC_BIND_CONSTS_SVH

// Register offsets, as seen on the plain register port
`define OFS_PRESET_SEL 12'h215
`define OFS_ROUTING 12'h216
`define OFS_REF_DIV 12'h217

// Reset values
`define RST_PRESET_SEL 8'h00
`define RST_ROUTING 8'h02
`define RST_REF_DIV 16'h0000
`define RST_RDATA 16'h0000
`define RST_PRESET 2'h0

// Field positions in the preset select register
`define SEL_FIRST_LSB 0
`define SEL_FIRST_MSB 1
`define SEL_SECOND_LSB 2
`define SEL_SECOND_MSB 3

// Field positions in the routing register
`define ROUTE_FOR_A_BIT 0
`define ROUTE_FOR_B_BIT 1

// Register widths
`define PRESET_SEL_W 8
`define ROUTING_W 8
`define REF_DIV_W 16

`endif

// ---- src/ddc_bind_pkg.sv ----
// Types shared by the preset and channel binding logic.
// Assumes the constants header is included by the files that need it.
package ddc_bind_pkg;

  typedef logic [11:0] reg_addr_t;
  typedef logic [15:0] reg_data_t;
  typedef logic [1:0] preset_t;

  // One access on the plain register port
  typedef struct packed {
    reg_addr_t addr;
    reg_data_t wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Preset source selection, in encoding order 0..3
  typedef enum logic [1:0] {
    MODE_REG_BOTH,
    MODE_PINS_SPLIT,
    MODE_PINS_FIRST_BOTH,
    MODE_RESERVED
  } preset_mode_t;

  typedef struct packed {
    preset_t first;
    preset_t second;
  } preset_pair_t;

  // Digital channel steering and power state
  typedef struct packed {
    logic a_from_conv_b;
    logic b_from_conv_b;
    logic a_powered_down;
    logic b_powered_down;
  } channel_ctl_t;

endpackage

// ---- src/pin_sync3.sv ----
// Three-stage synchroniser for asynchronous pin groups.
// Assumes the inputs may change at any time relative to clk.
`timescale 1ns/1ps

module pin_sync3 #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] pin_raw,
  output logic [W-1:0] pin_stable
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  always_comb
  begin
    d = q;
    d.s1 = pin_raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Accept a new level only once two later stages agree
    if (q.s2 == q.s3)
    begin
      d.stable = q.s3;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign pin_stable = q.stable;

endmodule

// ---- src/preset_resolve.sv ----
// Chooses the active oscillator preset of each down-converter.
// Assumes synchronised pins and register fields on the same clock.
`timescale 1ns/1ps

module preset_resolve (
  input wire ddc_bind_pkg::preset_mode_t mode,
  input wire logic single_channel_mode,
  input wire ddc_bind_pkg::preset_pair_t reg_sel,
  input wire ddc_bind_pkg::preset_pair_t pin_sel,
  input wire ddc_bind_pkg::preset_pair_t held,
  output ddc_bind_pkg::preset_pair_t active
);

  ddc_bind_pkg::preset_pair_t pick;

  always_comb
  begin
    pick = held;
    unique case (mode)
      ddc_bind_pkg::MODE_REG_BOTH:
      begin
        pick.first = reg_sel.first;
        pick.second = reg_sel.second;
      end
      ddc_bind_pkg::MODE_PINS_SPLIT:
      begin
        pick.first = pin_sel.first;
        pick.second = pin_sel.second;
      end
      ddc_bind_pkg::MODE_PINS_FIRST_BOTH:
      begin
        pick.first = pin_sel.first;
        pick.second = pin_sel.first;
      end
      ddc_bind_pkg::MODE_RESERVED:
      begin
        pick = held;
      end
    endcase
    if (single_channel_mode)
    begin
      pick.second = pick.first;
    end
    active = pick;
  end

endmodule

// ---- src/ddc_preset_and_channel_binding.sv ----
// Preset select, digital channel routing and oscillator reference
// divisor registers, with the steering they apply to the datapath.
// Assumes a plain register port on clk; mode, single channel and
// power-down levels come from logic on clk, preset pins from outside.
`timescale 1ns/1ps
`include "ddc_bind_consts.svh"

module ddc_preset_and_channel_binding (
  input wire logic clk,
  input wire logic rstn,
  input wire ddc_bind_pkg::reg_req_t bus_req,
  output ddc_bind_pkg::reg_data_t bus_rdata,
  input wire ddc_bind_pkg::preset_mode_t preset_source_mode,
  input wire logic single_channel_mode,
  input wire logic power_down_converter_a,
  input wire logic power_down_converter_b,
  input wire logic [1:0] preset_pins_first,
  input wire logic [1:0] preset_pins_second,
  output ddc_bind_pkg::preset_pair_t active_preset,
  output ddc_bind_pkg::channel_ctl_t channel_ctl,
  output logic [`REF_DIV_W-1:0] ref_divisor,
  output logic ref_divisor_enable
);

  typedef struct packed {
    logic [`PRESET_SEL_W-1:0] preset_sel;
    logic [`ROUTING_W-1:0] routing;
    logic [`REF_DIV_W-1:0] ref_div;
    ddc_bind_pkg::reg_data_t rdata;
    ddc_bind_pkg::preset_pair_t active;
    ddc_bind_pkg::channel_ctl_t chan;
    logic [`REF_DIV_W-1:0] div_out;
    logic div_en;
  } state_t;

  state_t q;
  state_t d;

  logic [3:0] pins_stable;
  ddc_bind_pkg::preset_pair_t pin_sel;
  ddc_bind_pkg::preset_pair_t reg_sel;
  ddc_bind_pkg::preset_pair_t resolved;

  // Address match on the register port
  function automatic logic hit(
    input ddc_bind_pkg::reg_addr_t addr,
    input ddc_bind_pkg::reg_addr_t ofs
  );
    hit = (addr == ofs);
  endfunction

  // Power state of the converter a digital channel is bound to
  function automatic logic bound_pd(
    input logic from_conv_b,
    input logic pd_a,
    input logic pd_b
  );
    bound_pd = from_conv_b ? pd_b : pd_a;
  endfunction

  // Read value of a register, narrow data in the low bits
  function automatic ddc_bind_pkg::reg_data_t readback(
    input ddc_bind_pkg::reg_addr_t addr,
    input state_t s
  );
    readback = `RST_RDATA;
    if (hit(addr, `OFS_PRESET_SEL))
    begin
      readback[`PRESET_SEL_W-1:0] = s.preset_sel;
    end
    else if (hit(addr, `OFS_ROUTING))
    begin
      readback[`ROUTING_W-1:0] = s.routing;
    end
    else if (hit(addr, `OFS_REF_DIV))
    begin
      readback = s.ref_div;
    end
  endfunction

  pin_sync3 #(
    .W(4)
  ) u_pin_sync (
    .clk(clk),
    .rstn(rstn),
    .pin_raw({preset_pins_first, preset_pins_second}),
    .pin_stable(pins_stable)
  );

  assign pin_sel.first = pins_stable[3:2];
  assign pin_sel.second = pins_stable[1:0];

  assign reg_sel.first =
    q.preset_sel[`SEL_FIRST_MSB:`SEL_FIRST_LSB];
  assign reg_sel.second =
    q.preset_sel[`SEL_SECOND_MSB:`SEL_SECOND_LSB];

  preset_resolve u_preset_resolve (
    .mode(preset_source_mode),
    .single_channel_mode(single_channel_mode),
    .reg_sel(reg_sel),
    .pin_sel(pin_sel),
    .held(q.active),
    .active(resolved)
  );

  always_comb
  begin
    d = q;

    // Register writes; unmapped addresses are ignored
    if (bus_req.wr)
    begin
      if (hit(bus_req.addr, `OFS_PRESET_SEL))
      begin
        d.preset_sel = bus_req.wdata[`PRESET_SEL_W-1:0];
      end
      if (hit(bus_req.addr, `OFS_ROUTING))
      begin
        d.routing = bus_req.wdata[`ROUTING_W-1:0];
      end
      if (hit(bus_req.addr, `OFS_REF_DIV))
      begin
        d.ref_div = bus_req.wdata;
      end
    end

    // Read data stands only in the cycle after the strobe
    if (bus_req.rd)
    begin
      d.rdata = readback(bus_req.addr, q);
    end
    else
    begin
      d.rdata = `RST_RDATA;
    end

    // Datapath settings come from stored values, never the raw bus
    // Registered datapath update
    d.active = resolved;

    d.chan.a_from_conv_b = q.routing[`ROUTE_FOR_A_BIT];
    d.chan.b_from_conv_b = q.routing[`ROUTE_FOR_B_BIT];

    d.chan.a_powered_down = bound_pd(q.routing[`ROUTE_FOR_A_BIT],
      power_down_converter_a, power_down_converter_b);
    d.chan.b_powered_down = bound_pd(q.routing[`ROUTE_FOR_B_BIT],
      power_down_converter_a, power_down_converter_b);

    d.div_out = q.ref_div;
    d.div_en = (q.ref_div != `RST_REF_DIV);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q.preset_sel <= `RST_PRESET_SEL;
      q.routing <= `RST_ROUTING;
      q.ref_div <= `RST_REF_DIV;
      q.rdata <= `RST_RDATA;
      q.active.first <= `RST_PRESET;
      q.active.second <= `RST_PRESET;
      q.chan.a_from_conv_b <= 1'h0;
      q.chan.b_from_conv_b <= 1'h1;
      q.chan.a_powered_down <= 1'h0;
      q.chan.b_powered_down <= 1'h0;
      q.div_out <= `RST_REF_DIV;
      q.div_en <= 1'h0;
    end
    else
    begin
      q <= d;
    end
  end

  assign bus_rdata = q.rdata;
  assign active_preset = q.active;
  assign channel_ctl = q.chan;
  assign ref_divisor = q.div_out;
  assign ref_divisor_enable = q.div_en;

endmodule

// ---- dv/ddc_bind_checker.sv ----
// Assertions on the ports of the preset and channel binding block.
// Assumes it is bound to the top module, one clock, async low reset.
`timescale 1ns/1ps

module ddc_bind_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire ddc_bind_pkg::reg_req_t bus_req,
  input wire ddc_bind_pkg::reg_data_t bus_rdata,
  input wire ddc_bind_pkg::preset_mode_t preset_source_mode,
  input wire logic single_channel_mode,
  input wire logic power_down_converter_a,
  input wire logic power_down_converter_b,
  input wire ddc_bind_pkg::preset_pair_t active_preset,
  input wire ddc_bind_pkg::channel_ctl_t channel_ctl,
  input wire logic [15:0] ref_divisor,
  input wire logic ref_divisor_enable
);
  logic reg_mode;
  logic wsel;
  logic wroute;
  logic wdiv;

  assign reg_mode = preset_source_mode == ddc_bind_pkg::MODE_REG_BOTH;
  assign wsel = bus_req.wr && bus_req.addr == 12'h215 && reg_mode;
  assign wroute = bus_req.wr && bus_req.addr == 12'h216;
  assign wdiv = bus_req.wr && bus_req.addr == 12'h217;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  AST_RDATA_IDLE: assert property (
    !$past(bus_req.rd) |-> bus_rdata == 16'h0000)
    else $error("read data not zero outside answer cycle");
  AST_DIV_WRITE: assert property (
    wdiv |-> ##2 ref_divisor == $past(bus_req.wdata, 2))
    else $error("divisor output does not follow write");
  AST_DIV_ENABLE: assert property (
    ref_divisor_enable == (ref_divisor != 16'h0000))
    else $error("divisor enable does not match nonzero divisor");
  AST_ROUTE_A: assert property (
    wroute |-> ##2 channel_ctl.a_from_conv_b == $past(bus_req.wdata[0], 2))
    else $error("channel A routing does not follow bit 0");
  AST_ROUTE_B: assert property (
    wroute |-> ##2 channel_ctl.b_from_conv_b == $past(bus_req.wdata[1], 2))
    else $error("channel B routing does not follow bit 1");
  AST_PD_A: assert property (
    $past(rstn) |-> channel_ctl.a_powered_down == (channel_ctl.a_from_conv_b
      ? $past(power_down_converter_b) : $past(power_down_converter_a)))
    else $error("channel A power-down not from bound converter");
  AST_PD_B: assert property (
    $past(rstn) |-> channel_ctl.b_powered_down == (channel_ctl.b_from_conv_b
      ? $past(power_down_converter_b) : $past(power_down_converter_a)))
    else $error("channel B power-down not from bound converter");
  AST_PRESET_A: assert property (
    wsel ##1 reg_mode |=> active_preset.first == $past(bus_req.wdata[1:0], 2))
    else $error("first preset not taken from bits 1:0");
  AST_PRESET_B: assert property (
    wsel ##1 reg_mode |=> active_preset.second == ($past(single_channel_mode)
      ? $past(bus_req.wdata[1:0], 2) : $past(bus_req.wdata[3:2], 2)))
    else $error("second preset wrong for channel mode");
  AST_MODE_HOLD: assert property (
    preset_source_mode == ddc_bind_pkg::MODE_RESERVED |=> $stable(active_preset))
    else $error("reserved mode changed active presets");

  COV_READ: cover property (bus_req.rd);
  COV_ROUTE: cover property (wroute);
  COV_PD: cover property (channel_ctl.a_powered_down);
  COV_HOLD: cover property (preset_source_mode == ddc_bind_pkg::MODE_RESERVED);
endmodule

// ---- dv/ddc_preset_and_channel_binding_bench.sv ----
// Self-checking bench for the preset and channel binding block.
// Assumes the package, design and checker are compiled before it.
`timescale 1ns/1ps

module ddc_preset_and_channel_binding_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic scm = 1'b0;
  logic pda = 1'b0;
  logic pdb = 1'b0;
  logic [1:0] pf = 2'h0;
  logic [1:0] ps = 2'h0;
  ddc_bind_pkg::reg_req_t req = '0;
  ddc_bind_pkg::preset_mode_t mode = ddc_bind_pkg::MODE_REG_BOTH;
  ddc_bind_pkg::reg_data_t rdata;
  ddc_bind_pkg::preset_pair_t act;
  ddc_bind_pkg::channel_ctl_t ctl;
  logic [15:0] div;
  logic div_en;
  int n_fail = 0;
  int comparisons = 0;

  ddc_preset_and_channel_binding dut_u (
    .clk(clk), .rstn(rstn), .bus_req(req), .bus_rdata(rdata),
    .preset_source_mode(mode), .single_channel_mode(scm),
    .power_down_converter_a(pda), .power_down_converter_b(pdb),
    .preset_pins_first(pf), .preset_pins_second(ps),
    .active_preset(act), .channel_ctl(ctl), .ref_divisor(div),
    .ref_divisor_enable(div_en)
  );

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic finish_test;
    if (n_fail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic set_in(input ddc_bind_pkg::preset_mode_t m, input logic s,
                        input int n);
    @(posedge clk);
    mode <= m;
    scm <= s;
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    chk(16'(ctl), 16'h0004);
    chk(16'(act), 16'h0000);
    chk({15'h0000, div_en}, 16'h0000);
    rd(12'h215, 16'h0000);
    rd(12'h216, 16'h0002);
    rd(12'h217, 16'h0000);
  endtask

  task automatic t_regs;
    wr(12'h215, 16'hFFF6);
    rd(12'h215, 16'h00F6);
    wr(12'h217, 16'hA5C3);
    chk(div, 16'hA5C3);
    chk({15'h0000, div_en}, 16'h0001);
    rd(12'h217, 16'hA5C3);
    wr(12'h218, 16'h00FF);
    rd(12'h218, 16'h0000);
    wr(12'h217, 16'h0000);
    chk({15'h0000, div_en}, 16'h0000);
  endtask

  task automatic t_route;
    logic [1:0] v;
    logic [1:0] p;
    for (int i = 0; i < 16; i++)
    begin
      v = i[3:2];
      p = i[1:0];
      wr(12'h216, {14'h0000, v});
      @(posedge clk);
      pda <= p[0];
      pdb <= p[1];
      @(posedge clk);
      #1;
      chk(16'(ctl), {12'h000, v[0], v[1], v[0] ? p[1] : p[0],
        v[1] ? p[1] : p[0]});
      rd(12'h216, {14'h0000, v});
    end
    wr(12'h216, 16'h0002);
    @(posedge clk);
    pda <= 1'b0;
    pdb <= 1'b0;
  endtask

  task automatic t_preset;
    wr(12'h215, 16'h0009);
    chk(16'(act), 16'h0006);
    set_in(ddc_bind_pkg::MODE_REG_BOTH, 1'b1, 1);
    chk(16'(act), 16'h0005);
    wr(12'h215, 16'h000E);
    chk(16'(act), 16'h000A);
    set_in(ddc_bind_pkg::MODE_REG_BOTH, 1'b0, 1);
    chk(16'(act), 16'h000B);
    pf <= 2'h1;
    ps <= 2'h3;
    set_in(ddc_bind_pkg::MODE_RESERVED, 1'b0, 1);
    wr(12'h215, 16'h0001);
    repeat (8) @(posedge clk);
    chk(16'(act), 16'h000B);
    set_in(ddc_bind_pkg::MODE_PINS_SPLIT, 1'b0, 8);
    chk(16'(act), 16'h0007);
    set_in(ddc_bind_pkg::MODE_PINS_FIRST_BOTH, 1'b0, 2);
    chk(16'(act), 16'h0005);
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    t_reset;
    t_regs;
    t_route;
    t_preset;
    finish_test;
  end

  initial
  begin
    #100000;
    n_fail++;
    finish_test;
  end
endmodule

bind ddc_preset_and_channel_binding ddc_bind_checker chk_u (.clk, .rstn,
  .bus_req, .bus_rdata, .preset_source_mode, .single_channel_mode,
  .power_down_converter_a, .power_down_converter_b, .active_preset,
  .channel_ctl, .ref_divisor, .ref_divisor_enable);
